// ==== src/tdq_pkg.sv ====
// Constants and register map of the trellis index dequantizer
package tdq_pkg;
  localparam int IDX_W = 16;
  localparam int NB_W = 5;
  localparam int COEF_W = 32;
  localparam int FRAC_W = 4;
  localparam int MANT_W = 11;
  localparam int MAG_W = 24;
  localparam int SH_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W = IDX_W + NB_W + 1;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TAB_W = 8;
  localparam int STATE_W = 3;
  localparam int K_W = 16;

  // Word addresses of the register file
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_BIAS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TAB0 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TAB3 = 4'h7;

  // Field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int STEP_RANGE_LSB = 0;
  localparam int STEP_EXP_LSB = 8;
  localparam int STEP_MANT_LSB = 16;
  localparam int BIAS_R_LSB = 0;
  localparam int BIAS_MAG_LSB = 8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_BIT = 4;
  localparam int STAT_K_LSB = 16;

  // Reset values
  localparam logic [NB_W-1:0] RANGE_RST = 5'h0_8;
  localparam logic [NB_W-1:0] EXP_RST = 5'h0_0;
  localparam logic [MANT_W-1:0] MANT_RST = 11'h000;
  localparam logic [FRAC_W-1:0] BIAS_R_RST = 4'h8;
  localparam logic [NB_W-1:0] MAG_RST = 5'h0_0;
  localparam logic [TAB_W-1:0] TAB_RST = 8'h00;
  localparam logic [STATE_W-1:0] STATE_INIT = 3'h0;
  localparam logic [K_W-1:0] K_INIT = 16'h0001;

  typedef enum logic {
    TDQ_MODE_FULL,
    TDQ_MODE_APPROX
  } tdq_mode_t;
endpackage : tdq_pkg

// ==== src/tdq_fifo.sv ====
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tdq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W:0] wr_ptr_reg;
  logic [PTR_W:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rd_ptr_reg[PTR_W-1:0]];
  assign push = ce_i && in_valid_i && !full;
  assign pop = ce_i && out_ready_i && !empty;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : tdq_fifo
`default_nettype wire

// ==== src/tdq_dequantizer.sv ====
// Trellis index dequantizer: full trellis and approximate scalar reconstruction
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Full trellis or approximate mode per block
// [R2] Partly decoded blocks should use approximate mode
// [R3] Full mode uses exponent/mantissa step size
// [R4] Full step is 2^(R-e-1)(1+mu/2^11)
// [R5] Block start: state zero, sequence index one
// [R6] States 0,1,4,5 first set; else second
// [R7] Second set negates plus/minus one indices
// [R8] Coefficient from selected set's reconstruction
// [R9] Next state from state and index parity
// [R10] One coefficient per index, in order
// [R11] Approximate step is twice the full step
// [R12] Approximate mode takes partial indices, no trellis
// [R13] Approximate: index one at start, clear LSB
// [R14] Zero gives zero; else add signed bias
// [R15] Host supplies bias, bit-planes, decoded counts
// [R16] Reconstruction offsets held in configurable tables
module tdq_dequantizer
  import tdq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [IDX_W-1:0] in_index_i,
  input wire logic [NB_W-1:0] in_planes_i,
  input wire logic in_last_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [COEF_W-1:0] out_coef_o,
  output logic out_last_o
);
  function automatic logic [IDX_W-1:0] abs_idx(input logic [IDX_W-1:0] q);
    abs_idx = q[IDX_W-1] ? IDX_W'(-q) : q;
  endfunction : abs_idx

  // Magnitude in FRAC_W fixed point times step mantissa, shifted by step exponent
  function automatic logic [COEF_W-1:0] scale(input logic [MAG_W-1:0] mag,
                                              input logic [MANT_W:0] mant,
                                              input logic signed [SH_W-1:0] sh);
    logic [63:0] prod;
    logic [63:0] res;
    prod = 64'(mag) * 64'(mant);
    if (sh >= 0) begin
      res = prod << sh;
    end else begin
      res = prod >> (-sh);
    end
    scale = {1'b0, res[COEF_W-2:0]};
  endfunction : scale

  function automatic logic [COEF_W-1:0] apply_sign(input logic [COEF_W-1:0] m,
                                                   input logic neg);
    apply_sign = neg ? COEF_W'(-m) : m;
  endfunction : apply_sign

  // Register file
  logic mode_cfg_reg;
  logic [NB_W-1:0] range_reg;
  logic [NB_W-1:0] exp_reg;
  logic [MANT_W-1:0] mant_reg;
  logic [FRAC_W-1:0] bias_r_reg;
  logic [NB_W-1:0] mag_planes_reg;
  logic [TAB_W-1:0] tab_reg [4];
  logic [DATA_W-1:0] rdata_reg;
  logic restart;

  // Stream state
  tdq_mode_t blk_mode_reg;
  tdq_mode_t cur_mode;
  logic [STATE_W-1:0] state_reg;
  logic [K_W-1:0] k_reg;
  logic out_valid_reg;
  logic [COEF_W-1:0] coef_reg;
  logic out_last_reg;

  logic [ENTRY_W-1:0] fifo_in;
  logic [ENTRY_W-1:0] fifo_out;
  logic fifo_valid;
  logic pop;
  logic at_start;
  logic [IDX_W-1:0] q;
  logic [NB_W-1:0] nb;
  logic last;
  logic union_sel;
  logic [IDX_W-1:0] q_full;
  logic [IDX_W-1:0] mag_full;
  logic [IDX_W-1:0] q_apx;
  logic [IDX_W-1:0] mag_apx;
  logic [MAG_W-1:0] mag_fx_full;
  logic [MAG_W-1:0] mag_fx_apx;
  logic [MAG_W-1:0] bias_fx;
  logic [NB_W-1:0] undecoded;
  logic signed [SH_W-1:0] sh_full;
  logic signed [SH_W-1:0] sh_apx;
  logic [MANT_W:0] mant_full;
  logic [COEF_W-1:0] coef_full;
  logic [COEF_W-1:0] coef_apx;
  logic [STATE_W-1:0] state_next;

  assign fifo_in = {in_last_i, in_planes_i, in_index_i};

  tdq_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out)
  );

  // Output stage stalls the FIFO, which stalls the decoder upstream
  assign pop = ce_i && fifo_valid && (!out_valid_reg || out_ready_i); // see [R10]
  assign q = fifo_out[IDX_W-1:0];
  assign nb = fifo_out[IDX_W +: NB_W];
  assign last = fifo_out[ENTRY_W-1];
  assign at_start = (k_reg == K_INIT);
  // Mode is sampled at the first index and held for the block
  assign cur_mode = at_start ? tdq_mode_t'(mode_cfg_reg) : blk_mode_reg; // see [R1]

  // Step exponents: full R-e-1, approximate one higher (doubled step)
  assign mant_full = {1'b1, mant_reg}; // see [R4]
  assign sh_full = SH_W'(signed'({3'b000, range_reg}) - signed'({3'b000, exp_reg})
                   - 8'sd1 - 8'(MANT_W + FRAC_W)); // see [R3]
  assign sh_apx = SH_W'(sh_full + 8'sd1); // see [R11]

  // Full mode
  assign union_sel = state_reg[1]; // see [R6]
  assign q_full = (union_sel && abs_idx(q) == IDX_W'(1)) ? IDX_W'(-q) : q; // see [R7]
  assign mag_full = abs_idx(q_full);
  assign mag_fx_full = (mag_full == '0) ? '0 :
                       MAG_W'({mag_full, {FRAC_W{1'b0}}}) +
                       MAG_W'(tab_reg[{union_sel, mag_full[0]}]); // see [R16]
  assign coef_full = apply_sign(scale(mag_fx_full, mant_full, sh_full),
                                q_full[IDX_W-1]); // see [R8]

  always_comb begin
    case (state_reg)
      3'h0: state_next = q[0] ? 3'h4 : 3'h0;
      3'h1: state_next = q[0] ? 3'h0 : 3'h4;
      3'h2: state_next = q[0] ? 3'h5 : 3'h1;
      3'h3: state_next = q[0] ? 3'h1 : 3'h5;
      3'h4: state_next = q[0] ? 3'h2 : 3'h6;
      3'h5: state_next = q[0] ? 3'h6 : 3'h2;
      3'h6: state_next = q[0] ? 3'h3 : 3'h7;
      default: state_next = q[0] ? 3'h7 : 3'h3;
    endcase
  end

  // Approximate mode: LSB of the magnitude is dropped
  assign mag_apx = abs_idx(q) & ~IDX_W'(1); // see [R13]
  assign q_apx = q[IDX_W-1] ? IDX_W'(-mag_apx) : mag_apx;
  assign undecoded = (nb >= mag_planes_reg) ? '0 : NB_W'(mag_planes_reg - nb);
  assign bias_fx = MAG_W'(bias_r_reg) << undecoded;
  assign mag_fx_apx = (mag_apx == '0) ? '0 :
                      MAG_W'({mag_apx, {FRAC_W{1'b0}}}) + bias_fx; // see [R14]
  assign coef_apx = apply_sign(scale(mag_fx_apx, mant_full, sh_apx),
                               q_apx[IDX_W-1]); // see [R14]

  // Register writes
  assign restart = ce_i && wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_RESTART_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_cfg_reg <= 1'b0;
      range_reg <= RANGE_RST;
      exp_reg <= EXP_RST;
      mant_reg <= MANT_RST;
      bias_r_reg <= BIAS_R_RST;
      mag_planes_reg <= MAG_RST;
      for (int i = 0; i < 4; i++) begin
        tab_reg[i] <= TAB_RST;
      end
    end else if (ce_i && wr_i) begin
      case (addr_i)
        ADDR_CTRL: mode_cfg_reg <= wdata_i[CTRL_MODE_BIT];
        ADDR_STEP: begin
          range_reg <= wdata_i[STEP_RANGE_LSB +: NB_W];
          exp_reg <= wdata_i[STEP_EXP_LSB +: NB_W];
          mant_reg <= wdata_i[STEP_MANT_LSB +: MANT_W];
        end
        ADDR_BIAS: begin
          bias_r_reg <= wdata_i[BIAS_R_LSB +: FRAC_W];
          mag_planes_reg <= wdata_i[BIAS_MAG_LSB +: NB_W];
        end
        default: begin
          if (addr_i >= ADDR_TAB0 && addr_i <= ADDR_TAB3) begin
            tab_reg[addr_i[1:0]] <= wdata_i[TAB_W-1:0]; // see [R16]
          end
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (ce_i) begin
      rdata_reg <= '0;
      if (rd_i) begin
        case (addr_i)
          ADDR_CTRL: rdata_reg[CTRL_MODE_BIT] <= mode_cfg_reg;
          ADDR_STEP: begin
            rdata_reg[STEP_RANGE_LSB +: NB_W] <= range_reg;
            rdata_reg[STEP_EXP_LSB +: NB_W] <= exp_reg;
            rdata_reg[STEP_MANT_LSB +: MANT_W] <= mant_reg;
          end
          ADDR_BIAS: begin
            rdata_reg[BIAS_R_LSB +: FRAC_W] <= bias_r_reg;
            rdata_reg[BIAS_MAG_LSB +: NB_W] <= mag_planes_reg;
          end
          ADDR_STATUS: begin
            rdata_reg[STAT_STATE_LSB +: STATE_W] <= state_reg;
            rdata_reg[STAT_MODE_BIT] <= blk_mode_reg;
            rdata_reg[STAT_K_LSB +: K_W] <= k_reg;
          end
          default: begin
            if (addr_i >= ADDR_TAB0 && addr_i <= ADDR_TAB3) begin
              rdata_reg[TAB_W-1:0] <= tab_reg[addr_i[1:0]];
            end
          end
        endcase
      end
    end
  end
  assign rdata_o = rdata_reg;

  // Trellis state and sequence index
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_INIT;
      k_reg <= K_INIT;
      blk_mode_reg <= TDQ_MODE_FULL;
    end else if (restart) begin
      state_reg <= STATE_INIT; // see [R5]
      k_reg <= K_INIT;
    end else if (pop) begin
      blk_mode_reg <= cur_mode;
      if (last) begin
        state_reg <= STATE_INIT; // see [R5]
        k_reg <= K_INIT; // see [R13]
      end else begin
        k_reg <= k_reg + 1'b1; // see [R10]
        if (cur_mode == TDQ_MODE_FULL) begin
          state_reg <= state_next; // see [R9]
        end
      end
    end
  end

  // Output register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_reg <= 1'b0;
      coef_reg <= '0;
      out_last_reg <= 1'b0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      coef_reg <= (cur_mode == TDQ_MODE_FULL) ? coef_full : coef_apx; // see [R12]
      out_last_reg <= last;
    end else if (ce_i && out_ready_i) begin
      out_valid_reg <= 1'b0;
    end
  end

  assign out_valid_o = out_valid_reg;
  assign out_coef_o = coef_reg;
  assign out_last_o = out_last_reg;

  chk_last_resets_state: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R5]
    pop && last |=> state_reg == STATE_INIT && k_reg == K_INIT)
    else $error("state or index not reinitialised after block end");

  chk_union_negate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R7]
    pop && state_reg[1] && q == IDX_W'(1) |-> q_full == {IDX_W{1'b1}})
    else $error("second set did not negate index one");

  chk_first_set_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R6]
    pop && !state_reg[1] |-> q_full == q)
    else $error("first set altered the index");

  chk_trellis_zero_odd: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R9]
    pop && !restart && !last && cur_mode == TDQ_MODE_FULL && state_reg == 3'h0 && q[0]
    |=> state_reg == 3'h4)
    else $error("state 0 with odd index did not move to 4");

  chk_trellis_six_even: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R9]
    pop && !restart && !last && cur_mode == TDQ_MODE_FULL && state_reg == 3'h6 && !q[0]
    |=> state_reg == 3'h7)
    else $error("state 6 with even index did not move to 7");

  chk_one_per_index: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R10]
    pop |=> out_valid_o && out_last_o == $past(last))
    else $error("index did not produce one coefficient");

  chk_approx_no_trellis: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R12]
    pop && !restart && !last && cur_mode == TDQ_MODE_APPROX |=> $stable(state_reg))
    else $error("approximate mode moved the trellis");

  chk_approx_small_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R14]
    pop && cur_mode == TDQ_MODE_APPROX && abs_idx(q) <= IDX_W'(1) |=> out_coef_o == '0)
    else $error("approximate index below two gave nonzero output");

  chk_step_doubled: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R11]
    pop && cur_mode == TDQ_MODE_APPROX && !mag_fx_apx[MAG_W-1]
    |-> coef_apx == apply_sign(scale(MAG_W'({mag_fx_apx, 1'b0}), mant_full, sh_full),
                               q_apx[IDX_W-1]))
    else $error("approximate step not twice the full step");

  chk_stall_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_coef_o))
    else $error("output changed while stalled");

  cov_full_block: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && last && cur_mode == TDQ_MODE_FULL && !at_start);
  cov_approx_block: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && last && cur_mode == TDQ_MODE_APPROX);
  cov_negation: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    pop && state_reg[1] && abs_idx(q) == IDX_W'(1));
  cov_fifo_full: cover property (@(posedge clk_i) disable iff (!rst_n_i) !in_ready_o);
endmodule : tdq_dequantizer
`default_nettype wire

// ==== test/tdq_decoder_model.sv ====
// Behavioural entropy decoder model feeding quantized indices
`timescale 1ns/1ps
`default_nettype none
module tdq_decoder_model
  import tdq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [IDX_W-1:0] index_o,
  output logic [NB_W-1:0] planes_o,
  output logic last_o
);
  logic [ENTRY_W-1:0] pend_q[$];
  int gap = 0;
  int idle_cnt = 0;

  task automatic push(input logic [IDX_W-1:0] idx, input logic [NB_W-1:0] nb,
                      input logic last);
    pend_q.push_back({last, nb, idx});
  endtask : push

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      index_o <= '0;
      planes_o <= '0;
      last_o <= 1'b0;
      idle_cnt <= 0;
    end else if (!valid_o || (ready_i && ce_i)) begin
      if (pend_q.size() > 0 && idle_cnt >= gap) begin
        {last_o, planes_o, index_o} <= pend_q.pop_front();
        valid_o <= 1'b1;
        idle_cnt <= 0;
      end else begin
        // Idle lines toggle so a stale value is never mistaken for data
        valid_o <= 1'b0;
        index_o <= ~index_o;
        planes_o <= ~planes_o;
        last_o <= ~last_o;
        idle_cnt <= idle_cnt + 1;
      end
    end
  end
endmodule : tdq_decoder_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking testbench of the trellis index dequantizer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tdq_pkg::*;
  // Full step with R=6, e=1, mu=1024 is 24; table entries even keep results whole
  localparam int STEP_F = 24;
  localparam int BIAS_R = 8;
  localparam int MAG_M = 3;
  logic clk_i, rst_n_i, ce_i, wr_i, rd_i, in_valid_i, in_ready_o, in_last_i;
  logic out_valid_o, out_ready_i, out_last_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic [IDX_W-1:0] in_index_i;
  logic [NB_W-1:0] in_planes_i;
  logic [COEF_W-1:0] out_coef_o;
  int fail_count = 0;
  int checks = 0;
  int st = 0;
  int sink_mode = 0;
  int cyc = 0;
  bit approx = 0;
  int tab[4] = '{2, 4, 6, 8};
  int ns_even[8] = '{0, 4, 1, 5, 6, 2, 7, 3};
  int ns_odd[8] = '{4, 0, 5, 1, 2, 6, 3, 7};
  logic [COEF_W:0] exp_q[$];

  tdq_dequantizer tdq_dequantizer_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_index_i(in_index_i),
    .in_planes_i(in_planes_i), .in_last_i(in_last_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_coef_o(out_coef_o), .out_last_o(out_last_o));

  tdq_decoder_model tdq_decoder_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .ready_i(in_ready_o), .valid_o(in_valid_i), .index_o(in_index_i),
    .planes_o(in_planes_i), .last_o(in_last_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [COEF_W:0] got, input logic [COEF_W:0] exp,
                       input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check({1'b0, rdata_o}, {1'b0, d}, what);
  endtask : rd_chk

  // Sink: always ready, every other cycle, or stalled
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    out_ready_i <= (sink_mode == 0) || (sink_mode == 1 && cyc[0]);
  end

  always @(posedge clk_i) begin
    if (rst_n_i && ce_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      check({out_last_o, out_coef_o}, (exp_q.size() > 0) ? exp_q.pop_front() : 'x,
            "coefficient");
    end
  end

  // Works out the coefficient one index must give, then hands it to the decoder
  task automatic send(input int q, input int nb, input bit last);
    int mag, sg, sh, x;
    sg = (q < 0) ? -1 : 1;
    mag = (q < 0) ? -q : q;
    if (approx) begin
      mag = mag & ~1;
      sh = (MAG_M > nb) ? MAG_M - nb : 0;
      x = mag * 2 * STEP_F + BIAS_R * (1 << sh) * 2 * STEP_F / 16;
      x = (mag == 0) ? 0 : sg * x;
    end else begin
      if (st[1] && mag == 1) sg = -sg;
      x = mag * STEP_F + tab[2 * st[1] + mag[0]] * STEP_F / 16;
      x = (q == 0) ? 0 : sg * x;
      st = q[0] ? ns_odd[st] : ns_even[st];
      if (last) st = 0;
    end
    exp_q.push_back({last, x[31:0]});
    tdq_decoder_model_inst.push(q[IDX_W-1:0], nb[NB_W-1:0], last);
  endtask : send

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check(exp_q.size(), 0, "drain");
    repeat (4) @(posedge clk_i);
  endtask : drain

  task automatic t_reset_regs;
    check(in_ready_o, 1, "ready after reset");
    check(out_valid_o, 0, "valid after reset");
    rd_chk(ADDR_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(ADDR_STEP, 32'h0000_0008, "step reset");
    rd_chk(ADDR_BIAS, 32'h0000_0008, "bias reset");
    rd_chk(ADDR_STATUS, 32'h0001_0000, "status reset");
    rd_chk(ADDR_TAB0, 32'h0000_0000, "table reset");
    rd_chk(4'h9, 32'h0000_0000, "unmapped read");
    reg_wr(4'h9, 32'hFFFF_FFFF);
    ce_i <= 1'b0;
    reg_wr(ADDR_STEP, 32'h0000_0101);
    ce_i <= 1'b1;
    rd_chk(ADDR_STEP, 32'h0000_0008, "write while frozen");
  endtask : t_reset_regs

  task automatic t_config;
    reg_wr(ADDR_STEP, 32'h0400_0106);
    reg_wr(ADDR_BIAS, 32'h0000_0308);
    for (int i = 0; i < 4; i++) reg_wr(ADDR_TAB0 + i[ADDR_W-1:0], tab[i][DATA_W-1:0]);
    rd_chk(ADDR_STEP, 32'h0400_0106, "step readback");
    rd_chk(ADDR_TAB3, 32'h0000_0008, "table readback");
  endtask : t_config

  task automatic t_full;
    int seq[15] = '{1, 2, 1, -1, 5, 1, -4, -1, 0, 3, 1, -1, 7, 2, 1};
    approx = 0;
    reg_wr(ADDR_CTRL, 32'h0000_0000);
    tdq_decoder_model_inst.gap = 2;
    sink_mode = 1;
    foreach (seq[i]) send(seq[i], 0, i == 14);
    drain();
    send(3, 0, 0);
    send(-1, 0, 0);
    send(2, 0, 0);
    drain();
    reg_wr(ADDR_CTRL, 32'h0000_0002);
    st = 0;
    rd_chk(ADDR_STATUS, 32'h0001_0000, "restart");
    foreach (seq[i]) send(-seq[i], 0, i == 6);
    drain();
  endtask : t_full

  task automatic t_approx;
    approx = 1;
    // Restart too: the last full block was left open, so the mode would not latch
    reg_wr(ADDR_CTRL, 32'h0000_0003);
    sink_mode = 0;
    tdq_decoder_model_inst.gap = 0;
    send(5, 3, 0);
    send(-7, 1, 0);
    send(1, 3, 0);
    send(0, 2, 0);
    send(6, 0, 0);
    send(-2, 5, 1);
    drain();
  endtask : t_approx

  task automatic t_fifo;
    sink_mode = 2;
    for (int i = 0; i < 40; i++) send(2 * i - 30, i % 4, i == 39);
    repeat (60) @(posedge clk_i);
    check(in_ready_o, 0, "fifo full");
    sink_mode = 1;
    drain();
    check(in_ready_o, 1, "fifo empty");
  endtask : t_fifo

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset_regs();
    t_config();
    t_full();
    t_approx();
    t_fifo();
    results();
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule : testbench
`default_nettype wire
